// ---- logic/ppmc_port.sv ----
/*
 Port pin mode control: one 16-pin port with data latch, direction, mode
 control, function selects, open-drain select and the debug mode register.
 Assumes pins synchronous to ref_clk, Avalon-MM master on the register side,
 and a system reset controller that flags which reset source fired.
*/
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module ppmc_port (
	// clock and resets
	input  wire logic                          ref_clk,
	input  wire logic                          rst,
	input  wire logic                          pin_reset,
	// avalon-mm slave
	input  wire logic [ppmc_pkg::ADDR_W-1:0]   avs_address,
	input  wire logic                          avs_read,
	input  wire logic                          avs_write,
	input  wire logic [31:0]                   avs_writedata,
	input  wire logic [3:0]                    avs_byteenable,
	output logic [31:0]                        avs_readdata,
	output logic                               avs_waitrequest,
	// pins
	input  wire logic [ppmc_pkg::PORT_W-1:0]   pin_in,
	output ppmc_pkg::ppmc_pin_drv_t            pin_drv,
	// peripherals
	input  wire ppmc_pkg::ppmc_alt_drv_t       alt_drv,
	output logic [ppmc_pkg::PORT_W-1:0]        alt_in,
	output logic [ppmc_pkg::PORT_W-1:0]        alt_func_select,
	output logic [ppmc_pkg::PORT_W-1:0]        alt_func_select_ext,
	// debug reset pin control
	output logic                               debug_enable_bit,
	output logic                               debug_pulldown_on
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [ppmc_pkg::PORT_W-1:0] latch_q;
	logic [ppmc_pkg::PORT_W-1:0] dir_q;
	logic [ppmc_pkg::PORT_W-1:0] mode_q;
	logic [ppmc_pkg::PORT_W-1:0] fsel_q;
	logic [ppmc_pkg::PORT_W-1:0] fselx_q;
	logic [ppmc_pkg::PORT_W-1:0] od_q;
	logic                        dbg_q;
	logic                        ack_q;
	logic [31:0]                 rdata_q;
	logic [ppmc_pkg::PORT_W-1:0] rd_port;
	logic                        wr_go;

	// merge bytes of a write into a 16-bit register
	function automatic logic [ppmc_pkg::PORT_W-1:0] merge16(
		input logic [ppmc_pkg::PORT_W-1:0] old,
		input logic [31:0]                 wd,
		input logic [3:0]                  be
	);
		logic [ppmc_pkg::PORT_W-1:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = wd[7:0];
		end
		if (be[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	// one wait state: answer lands at the second edge of a request
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign wr_go = avs_write & ack_q;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end

	assign rd_port = (latch_q & ~dir_q) | (pin_in & dir_q);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata_q <= ppmc_pkg::RD_NONE;
		end else if (avs_read & ~ack_q) begin
			if (avs_address == ppmc_pkg::OFS_DATA) begin
				rdata_q <= {16'h0000, rd_port};
			end else if (avs_address == ppmc_pkg::OFS_DIR) begin
				rdata_q <= {16'h0000, dir_q};
			end else if (avs_address == ppmc_pkg::OFS_MODE) begin
				rdata_q <= {16'h0000, mode_q};
			end else if (avs_address == ppmc_pkg::OFS_FSEL) begin
				rdata_q <= {16'h0000, fsel_q};
			end else if (avs_address == ppmc_pkg::OFS_FSELX) begin
				rdata_q <= {16'h0000, fselx_q};
			end else if (avs_address == ppmc_pkg::OFS_ODSEL) begin
				rdata_q <= {16'h0000, od_q};
			end else if (avs_address == ppmc_pkg::OFS_DBG) begin
				rdata_q <= {31'h0000_0000, dbg_q};
			end else begin
				rdata_q <= ppmc_pkg::RD_NONE;
			end
		end
	end
	assign avs_readdata = rdata_q;

	// ----------------------------------------
	// port data latch
	// ----------------------------------------
	// write lands in latch only
	// enabled bytes copied whole, input bits included
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			latch_q <= ppmc_pkg::RST_DATA;
		end else if (wr_go && avs_address == ppmc_pkg::OFS_DATA) begin
			latch_q <= merge16(latch_q, avs_writedata, avs_byteenable);
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dir_q   <= ppmc_pkg::RST_DIR;
			mode_q  <= ppmc_pkg::RST_ZERO;
			fsel_q  <= ppmc_pkg::RST_ZERO;
			fselx_q <= ppmc_pkg::RST_ZERO;
			od_q    <= ppmc_pkg::RST_ZERO;
		end else if (wr_go) begin
			if (avs_address == ppmc_pkg::OFS_DIR) begin
				dir_q <= merge16(dir_q, avs_writedata, avs_byteenable);
			end else if (avs_address == ppmc_pkg::OFS_MODE) begin
				mode_q <= merge16(mode_q, avs_writedata, avs_byteenable);
			end else if (avs_address == ppmc_pkg::OFS_FSEL) begin
				fsel_q <= merge16(fsel_q, avs_writedata, avs_byteenable);
			end else if (avs_address == ppmc_pkg::OFS_FSELX) begin
				fselx_q <= merge16(fselx_q, avs_writedata, avs_byteenable);
			end else if (avs_address == ppmc_pkg::OFS_ODSEL) begin
				od_q <= merge16(od_q, avs_writedata, avs_byteenable);
			end
		end
	end

	// ----------------------------------------
	// debug mode register
	// ----------------------------------------
	// only pin reset reinitialises; other resets leave it
	always_ff @(posedge ref_clk) begin
		if (pin_reset) begin
			dbg_q <= ppmc_pkg::RST_DBG;
		end else if (wr_go && avs_address == ppmc_pkg::OFS_DBG && avs_byteenable[0]) begin
			dbg_q <= avs_writedata[ppmc_pkg::DBG_EN_BIT];
		end
	end
	assign debug_enable_bit = dbg_q;
	assign debug_pulldown_on = dbg_q;

	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	// latch drives in port mode, peripheral in alternate mode
	// open drain on output-direction bits in port mode and on peripheral-driven bits in alternate mode
	always_comb begin
		for (int i = 0; i < ppmc_pkg::PORT_W; i++) begin
			if (mode_q[i]) begin
				pin_drv.out[i] = alt_drv.out[i] & ~(od_q[i] & alt_drv.out[i]);
				pin_drv.oe[i]  = alt_drv.oe[i] & ~(od_q[i] & alt_drv.out[i]);
			end else begin
				pin_drv.out[i] = latch_q[i];
				pin_drv.oe[i]  = ~dir_q[i] & ~(od_q[i] & latch_q[i]);
			end
		end
	end

	// alternate input forced low in port mode
	assign alt_in = pin_in & mode_q;
	assign alt_func_select = fsel_q;
	assign alt_func_select_ext = fselx_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_read_mux_data: assert property (@(posedge ref_clk) disable iff (rst)
		(avs_read && !ack_q && avs_address == ppmc_pkg::OFS_DATA) |=>
		avs_readdata[15:0] == (($past(latch_q) & ~$past(dir_q)) | ($past(pin_in) & $past(dir_q))))
		else $error("data read mismatch");

	a_write_latch_only: assert property (@(posedge ref_clk) disable iff (rst)
		(wr_go && avs_address == ppmc_pkg::OFS_DATA && avs_byteenable[1:0] == 2'h3) |=>
		latch_q == $past(avs_writedata[15:0]) && $stable(dir_q) && $stable(mode_q))
		else $error("data write touched more than latch");

	a_alt_in_low: assert property (@(posedge ref_clk) disable iff (rst)
		(alt_in & ~mode_q) == 16'h0000)
		else $error("alternate input not gated");

	a_od_input_off: assert property (@(posedge ref_clk) disable iff (rst)
		(!mode_q[0] && dir_q[0]) |-> !pin_drv.oe[0])
		else $error("input pin driven");

	a_od_output_low: assert property (@(posedge ref_clk) disable iff (rst)
		(!mode_q[0] && !dir_q[0] && od_q[0] && latch_q[0]) |-> !pin_drv.oe[0])
		else $error("open drain drove high");

	a_port_drive: assert property (@(posedge ref_clk) disable iff (rst)
		(!mode_q[1] && !dir_q[1] && !od_q[1]) |-> pin_drv.oe[1] && pin_drv.out[1] == latch_q[1])
		else $error("port output not from latch");

	a_dbg_hold: assert property (@(posedge ref_clk) disable iff (pin_reset)
		(rst && !(avs_write && avs_address == ppmc_pkg::OFS_DBG)) |=> $stable(dbg_q))
		else $error("debug register lost on reset");

	a_dbg_pinrst: assert property (@(posedge ref_clk)
		pin_reset |=> debug_pulldown_on && debug_enable_bit)
		else $error("pull-down not set after pin reset");

	a_bus_answer: assert property (@(posedge ref_clk) disable iff (rst)
		(avs_write && !ack_q) |=> !avs_waitrequest)
		else $error("write not answered in one wait");

	c_alt_mode: cover property (@(posedge ref_clk) disable iff (rst) mode_q == 16'hFFFF);
	c_dbg_clear: cover property (@(posedge ref_clk) disable iff (rst) $fell(dbg_q));
	c_mixed_read: cover property (@(posedge ref_clk) disable iff (rst)
		avs_read && dir_q != 16'h0000 && dir_q != 16'hFFFF);

endmodule

`default_nettype wire

// ---- shared/ppmc_pkg.sv ----
/*
 Package for the port pin mode control block: register map, field layout,
 reset values and carrier structs. Assumes an Avalon-MM slave with 32-bit
 data, word addressing by byte address, and one 16-bit port.
*/
// Behaviour
// - data read returns latch for output bits, pin level for input bits
// - data write updates only the output latch in every mode
// - alternate input is forced low while mode control bit is zero
// - open drain applies in both modes: output direction bits in port mode, peripheral bits in alternate mode
// - single-bit write may copy read-back into untargeted input latches
// - watchdog, clock monitor, low voltage resets keep the debug mode register
// - pull-down on debug reset pin connected until debug enable is cleared
`default_nettype none
package ppmc_pkg;

	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int unsigned PORT_W = 16;
	localparam int unsigned ADDR_W = 8;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] OFS_DATA  = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_DIR   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_MODE  = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_FSEL  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_FSELX = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_ODSEL = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_DBG   = 8'h18;

	// ----------------------------------------
	// reset values and fields
	// ----------------------------------------
	localparam logic [PORT_W-1:0] RST_DATA = 16'h0000;
	localparam logic [PORT_W-1:0] RST_DIR  = 16'hFFFF;
	localparam logic [PORT_W-1:0] RST_ZERO = 16'h0000;
	localparam logic              RST_DBG  = 1'b1;
	localparam int unsigned       DBG_EN_BIT = 0;
	localparam logic [31:0]       RD_NONE  = 32'h0000_0000;

	// pin-side carrier
	typedef struct packed {
		logic [PORT_W-1:0] out;
		logic [PORT_W-1:0] oe;
	} ppmc_pin_drv_t;

	// peripheral-side carrier, one lane per pin
	typedef struct packed {
		logic [PORT_W-1:0] out;
		logic [PORT_W-1:0] oe;
	} ppmc_alt_drv_t;

endpackage
`default_nettype wire

// ---- verif/ppmc_far_side.sv ----
/*
 Far-side model: pads with an outside level source, and the alternate
 peripherals. Assumes undriven pads take the level the bench puts on ext_level.
*/
`timescale 1ns/1ps
`default_nettype none
module ppmc_far_side (
	// pad side
	input  wire ppmc_pkg::ppmc_pin_drv_t pin_drv,
	input  wire logic [15:0]             ext_level,
	output logic [15:0]                  pin_in,
	// peripheral side
	input  wire logic [15:0]             alt_pattern,
	output ppmc_pkg::ppmc_alt_drv_t      alt_drv
);
	// a driven pad shows the device's value, else the outside level
	assign pin_in = (pin_drv.oe & pin_drv.out) | (~pin_drv.oe & ext_level);
	// peripherals always drive; the bench parks alt_pattern only before the last return to port mode
	assign alt_drv = {alt_pattern, 16'hFFFF};
endmodule
`default_nettype wire

// ---- verif/port_pin_mode_control_test.sv ----
/*
 Self-checking bench for the port pin mode control block.
 Assumes the one-wait-state Avalon-MM slave described for ppmc_port.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module port_pin_mode_control_test;
	logic                    ref_clk = 0, rst = 1, pin_reset = 1, rd = 0, wr = 0, wreq, dbg, pd;
	logic [7:0]              adr = 0;
	logic [3:0]              be = 4'hF;
	logic [31:0]             wdat = 0, rdat, q;
	logic [15:0]             ext = 0, pat = 0, pin_in, alt_in, fs, fsx, lat, dir, m, lv;
	ppmc_pkg::ppmc_pin_drv_t pdrv;
	ppmc_pkg::ppmc_alt_drv_t adrv;
	int                      err_total = 0, samples_checked = 0, cyc = 0;
	// pad standing in for the shared debug reset pin
	localparam logic [15:0]  DBG_PAD = 16'h0020;
	always #4 ref_clk = ~ref_clk;
	ppmc_port ppmc_port_i (.ref_clk(ref_clk), .rst(rst), .pin_reset(pin_reset),
		.avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
		.avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq),
		.pin_in(pin_in), .pin_drv(pdrv), .alt_drv(adrv), .alt_in(alt_in),
		.alt_func_select(fs), .alt_func_select_ext(fsx),
		.debug_enable_bit(dbg), .debug_pulldown_on(pd));
	ppmc_far_side ppmc_far_side_i (.pin_drv(pdrv), .ext_level(ext), .pin_in(pin_in),
		.alt_pattern(pat), .alt_drv(adrv));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] lvl(input logic [15:0] l, d, mm, e, p);
		return (mm & p) | (~mm & ~d & l) | (~mm & d & e);
	endfunction
	task tally_and_finish;
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// request held until waitrequest is seen low at a rising edge; data taken there
	task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		adr <= a;
		wdat <= {16'h0000, d};
		wr <= w;
		rd <= ~w;
		do @(posedge ref_clk); while (wreq !== 1'b0);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		// let outputs settle before the caller compares them
		@(negedge ref_clk);
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish;
		end
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		void'($urandom(32'h426C5A92));
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		pin_reset <= 1'b0;
		bus(0, ppmc_pkg::OFS_DBG, 0);
		`CHK(q, 32'h0000_0001)
		`CHK(pd, 1'b1)
		bus(0, 8'h40, 0);
		`CHK(q, ppmc_pkg::RD_NONE)
		$display("reset test done");
		for (int i = 0; i < 10; i++) begin
			lat = 16'($urandom);
			dir = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
			m = (i < 2) ? 16'h0000 : 16'($urandom);
			@(posedge ref_clk);
			ext <= 16'($urandom) & ~DBG_PAD;
			pat <= 16'($urandom);
			bus(1, ppmc_pkg::OFS_DATA, lat);
			bus(1, ppmc_pkg::OFS_DIR, dir);
			bus(1, ppmc_pkg::OFS_MODE, m);
			lv = lvl(lat, dir, m, ext, pat);
			bus(0, ppmc_pkg::OFS_DATA, 0);
			`CHK(q[15:0], (lat & ~dir) | (lv & dir))
			`CHK(alt_in, lv & m)
			`CHK(pdrv.oe, m | ~dir)
		end
		$display("mixed read test done");
		bus(1, ppmc_pkg::OFS_MODE, 16'h0000);
		`CHK(alt_in, 16'h0000)
		bus(1, ppmc_pkg::OFS_ODSEL, 16'h0000);
		// key return only
		// bit1 select set, extended clear, before mode control
		bus(1, ppmc_pkg::OFS_FSEL, 16'h0002);
		bus(1, ppmc_pkg::OFS_FSELX, 16'hFFFD);
		bus(1, ppmc_pkg::OFS_MODE, 16'hFFFF);
		`CHK(fs, 16'h0002)
		`CHK(fsx, 16'hFFFD)
		@(posedge ref_clk);
		pat <= 16'($urandom);
		@(negedge ref_clk);
		`CHK(pdrv.out, pat)
		bus(1, ppmc_pkg::OFS_DATA, 16'h5A5A);
		bus(0, ppmc_pkg::OFS_MODE, 0);
		`CHK(q[15:0], 16'hFFFF)
		bus(1, ppmc_pkg::OFS_DIR, 16'h0000);
		bus(0, ppmc_pkg::OFS_DATA, 0);
		`CHK(q[15:0], 16'h5A5A)
		bus(1, ppmc_pkg::OFS_DATA, 16'h5A5A);
		// peripheral stopped before pins go back to port use
		@(posedge ref_clk);
		pat <= 16'h0000;
		bus(1, ppmc_pkg::OFS_MODE, 16'h0000);
		`CHK(pdrv.out, 16'h5A5A)
		// upper byte lane only
		@(posedge ref_clk);
		be <= 4'h2;
		bus(1, ppmc_pkg::OFS_DATA, 16'hC3C3);
		@(posedge ref_clk);
		be <= 4'hF;
		bus(0, ppmc_pkg::OFS_DATA, 0);
		`CHK(q[15:0], 16'hC35A)
		$display("alternate test done");
		bus(1, ppmc_pkg::OFS_DATA, 16'h0000);
		bus(1, ppmc_pkg::OFS_ODSEL, 16'hFFFF);
		`CHK(pdrv.oe, 16'hFFFF)
		bus(1, ppmc_pkg::OFS_DATA, 16'hFF00);
		`CHK(pdrv.oe & pdrv.out, 16'h0000)
		bus(1, ppmc_pkg::OFS_DIR, 16'hFFFF);
		`CHK(pdrv.oe, 16'h0000)
		$display("open drain test done");
		bus(1, ppmc_pkg::OFS_DBG, 16'h0000);
		`CHK(pd, 1'b0)
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		bus(0, ppmc_pkg::OFS_DBG, 0);
		`CHK(q, 32'h0000_0000)
		@(posedge ref_clk);
		pin_reset <= 1'b1;
		@(posedge ref_clk);
		pin_reset <= 1'b0;
		@(negedge ref_clk);
		`CHK(dbg, 1'b1)
		`CHK(pd, 1'b1)
		$display("debug test done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
